/* dv/psl_mdio_station.sv */
// Management station model: drives frames, samples reads on rising edges.
// Assumes a pull-up on the data line; runs on sys_clk falling edges.
`default_nettype none

module psl_mdio_station (
   // Clock
   input wire logic sys_clk,
   // Management pins
   output var logic mdcPin,
   output wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOeN
);
   // ********************
   // Frame engine
   // ********************
   logic stOe = 1'b0;
   logic stBit = 1'b1;
   initial mdcPin = 1'b0;
   // Wired line: either party pulls low, the pull-up wins otherwise
   assign mdioIn = (stOe ? stBit : 1'b1) & (mdioOeN ? 1'b1 : mdioOut);

   task automatic bit_cyc(input logic b, input logic oe, output logic s);
      mdcPin = 1'b0;
      stOe = oe;
      stBit = b;
      repeat (10) @(negedge sys_clk);
      s = mdioIn;
      mdcPin = 1'b1;
      repeat (10) @(negedge sys_clk);
   endtask : bit_cyc

   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic s;
      hdr = {2'b01, op, phy, ra};
      repeat (32) bit_cyc(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
      bit_cyc(1'b1, op == 2'b01, s);
      bit_cyc(1'b0, op == 2'b01, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(wd[i], op == 2'b01, s);
         rd[i] = s;
      end
      mdcPin = 1'b0;
      stOe = 1'b0;
   endtask : xfer
endmodule : psl_mdio_station

`default_nettype wire

/* dv/psl_port_status_led_bench.sv */
// Self-checking bench of the port status indicator block, two ports.
// Assumes short millisecond counts: 10 cycles a millisecond.
`default_nettype none

module psl_port_status_led_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ********************
   // Harness
   // ********************
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] txActive = '0;
   logic [1:0] rxActive = '0;
   logic [1:0] linkUp = '0;
   logic mdcPin;
   logic mdioOut;
   logic mdioOeN;
   wire logic mdioIn;
   logic [5:0] ledOn;
   logic [1:0] portResetPulse;
   int errors = 0;
   int total_checks = 0;
   int pulse0 = 0;
   int pulse1 = 0;

   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (portResetPulse[0] === 1'b1) pulse0++;
      if (portResetPulse[1] === 1'b1) pulse1++;
   end

   psl_port_status_led #(.PORTS(2), .MS_CYCLES(10), .STRETCH_MS(3), .BLINK_MS(2)) uut (
      .sys_clk, .rst, .txActive, .rxActive, .linkUp, .mdcPin, .mdioIn, .mdioOut,
      .mdioOeN, .ledOn, .portResetPulse);
   psl_mdio_station st (.sys_clk, .mdcPin, .mdioIn, .mdioOut, .mdioOeN);

   task automatic end_sim();
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick

   task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] d;
      st.xfer(2'b01, phy, ra, wd, d);
   endtask : wr

   task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra,
         input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] d;
      st.xfer(2'b10, phy, ra, 16'h0000, d);
      check(d & mask, exp);
   endtask : rd_chk

   // ********************
   // Scenarios
   // ********************
   task automatic test_registers();
      linkUp = 2'b01;
      tick(4);
      rd_chk(5'h00, 5'h01, 16'h0004, 16'h0004);
      rd_chk(5'h00, 5'h11, 16'h0400, 16'h0400);
      rd_chk(5'h01, 5'h01, 16'h0004, 16'h0000);
      rd_chk(5'h00, 5'h14, 16'hffff, 16'hd102);
      rd_chk(5'h00, 5'h05, 16'hffff, 16'h0000);
   endtask : test_registers

   task automatic test_link_activity();
      logic seen;
      seen = 1'b0;
      linkUp = 2'b00;
      txActive = 2'b01;
      repeat (60) begin
         tick(1);
         seen |= ledOn[2];
      end
      check(seen, 1'b0);
      linkUp = 2'b01;
      txActive = 2'b00;
      tick(50);
      check(ledOn[2], 1'b1);
      // Traffic only once the link indicator has been seen lit
      txActive = 2'b01;
      seen = 1'b0;
      repeat (60) begin
         tick(1);
         seen |= !ledOn[2];
      end
      check(seen, 1'b1);
      check(ledOn[1:0], 2'b10);
      txActive = 2'b00;
   endtask : test_link_activity

   task automatic test_stretch_off();
      wr(5'h00, 5'h14, 16'h2100);
      rd_chk(5'h01, 5'h14, 16'h0002, 16'h0000);
      txActive = 2'b01;
      tick(1);
      check(ledOn[2:0], 3'b110);
      txActive = 2'b00;
      rxActive = 2'b01;
      tick(1);
      check(ledOn[2:0], 3'b101);
      rxActive = 2'b00;
      tick(1);
      check(ledOn[2:0], 3'b000);
      txActive = 2'b10;
      tick(1);
      txActive = 2'b00;
      tick(2);
      check(ledOn[4], 1'b0);
   endtask : test_stretch_off

   task automatic test_stretch_on();
      logic low;
      low = 1'b0;
      wr(5'h01, 5'h14, 16'hd102);
      txActive = 2'b01;
      tick(1);
      txActive = 2'b00;
      // Hold ends two to three ticks after the event, whatever the tick phase
      tick(15);
      check(ledOn[1], 1'b1);
      tick(20);
      check(ledOn[1], 1'b0);
      // Receive packets and gaps twice as long as transmit ones, to test beating
      for (int i = 0; i < 80; i++) begin
         txActive[0] = i[1];
         rxActive[0] = i[2];
         tick(1);
         if (i > 1) low |= !ledOn[2];
      end
      check(low, 1'b0);
      txActive = 2'b00;
      rxActive = 2'b00;
   endtask : test_stretch_on

   task automatic test_port_reset();
      wr(5'h00, 5'h00, 16'h1234);
      rd_chk(5'h00, 5'h00, 16'hffff, 16'h1234);
      pulse0 = 0;
      pulse1 = 0;
      wr(5'h00, 5'h00, 16'h8000);
      tick(4);
      check(16'(pulse0), 16'h0001);
      check(16'(pulse1), 16'h0000);
      rd_chk(5'h00, 5'h00, 16'hffff, 16'h0000);
      rd_chk(5'h00, 5'h14, 16'hffff, 16'hd102);
   endtask : test_port_reset

   initial begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      end_sim();
   end

   initial begin
      tick(20);
      rst = 1'b0;
      tick(4);
      test_registers();
      test_link_activity();
      test_stretch_off();
      test_stretch_on();
      test_port_reset();
      end_sim();
   end
endmodule : psl_port_status_led_bench

`default_nettype wire

/* dv/psl_port_status_led_checker.sv */
// Assertions on the pins of the port status indicator block.
// Assumes the management clock half period is at least eight sys_clk cycles.
`default_nettype none

module psl_port_status_led_checker #(
   parameter int PORTS = 6
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Watched pins
   input wire logic mdcPin,
   input wire logic mdioOut,
   input wire logic mdioOeN,
   input wire logic [3*PORTS-1:0] ledOn,
   input wire logic [PORTS-1:0] portResetPulse
);
   // ********************
   // Pin relations
   // ********************
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   rel_values_a: assert property (
      $fell(rst) |-> mdioOut && mdioOeN && ledOn == '0 && portResetPulse == '0)
      else $error("outputs not idle after reset");
   pulse_width_a: assert property (
      |portResetPulse |=> portResetPulse == '0)
      else $error("port reset pulse too long");
   pulse_single_a: assert property (
      $onehot0(portResetPulse)) else $error("several ports reset at once");
   pulse_quiet_a: assert property (
      |portResetPulse |-> mdioOeN) else $error("port reset during a read");
   idle_high_a: assert property (
      mdioOeN |-> mdioOut) else $error("data pin not high while released");
   drive_hold_a: assert property (
      $fell(mdioOeN) |=> !mdioOeN [*8]) else $error("read drive too short");
   drive_edge_a: assert property (
      $fell(mdioOeN) |-> mdcPin && !mdioOut) else $error("bad turnaround drive");
   // Bits move only after a rising management clock edge
   bit_edge_a: assert property (
      !mdioOeN && $changed(mdioOut) |-> mdcPin) else $error("read bit off the clock");
   release_edge_a: assert property (
      $rose(mdioOeN) |-> mdcPin && mdioOut) else $error("bad release of data pin");
endmodule : psl_port_status_led_checker

bind psl_port_status_led psl_port_status_led_checker #(.PORTS(PORTS)) chk (
   .sys_clk(sys_clk),
   .rst(rst),
   .mdcPin(mdcPin),
   .mdioOut(mdioOut),
   .mdioOeN(mdioOeN),
   .ledOn(ledOn),
   .portResetPulse(portResetPulse)
);

`default_nettype wire

/* hdl/psl_port_status_led.sv */
// Per-port status indicators with a serial management register slave.
// Assumes tx, rx and link inputs come from logic on sys_clk; the management
// clock and data pins are asynchronous and are synchronised here.
//
// How it works
// - Continuous traffic keeps activity steadily lit
// - Indicator bit 1 zero disables stretching
// - One stretch bit serves every port
// - Three 4-bit fields select indicator functions
// - Code 1101 shows link, activity only linked
// - Link reads at status 2, extended 10
// - Control bit 15 resets the addressed port
// - Indicators may show transmit or receive alone
// - Activity is transmit OR receive status
`include "psl_consts.svh"
`default_nettype none

module psl_port_status_led #(
   parameter int PORTS = 6,
   parameter logic [4:0] PHY_BASE = `PSL_PHY_BASE,
   parameter int MS_CYCLES = `PSL_MS_NS / `PSL_CLK_PERIOD_NS,
   parameter int STRETCH_MS = `PSL_STRETCH_MS,
   parameter int BLINK_MS = `PSL_BLINK_MS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Port traffic and link state
   input wire logic [PORTS-1:0] txActive,
   input wire logic [PORTS-1:0] rxActive,
   input wire logic [PORTS-1:0] linkUp,
   // Management pins
   input wire logic mdcPin,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOeN,
   // Indicators and port resets
   output logic [3*PORTS-1:0] ledOn,
   output logic [PORTS-1:0] portResetPulse
);

   localparam int IW = (PORTS > 1) ? $clog2(PORTS) : 1;
   localparam int MW = $clog2(MS_CYCLES);
   localparam int SW = $clog2(STRETCH_MS + 1);
   localparam int BW = $clog2(BLINK_MS + 1);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [1:0] mdcSync;
   logic [1:0] mdioSync;
   logic mdcLast;
   logic mdcRise;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mdcSync <= 2'h0;
         mdioSync <= 2'h3;
         mdcLast <= 1'b0;
      end else begin
         mdcSync <= {mdcSync[0], mdcPin};
         mdioSync <= {mdioSync[0], mdioIn};
         mdcLast <= mdcSync[1];
      end
   end
   assign mdcRise = mdcSync[1] & ~mdcLast;

   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [14:0] ctrlReg [PORTS];
   logic [11:0] selReg [PORTS];
   logic stretchEnReg;

   function automatic logic [15:0] regRead(input logic [4:0] ra, input logic [14:0] ctl,
                                           input logic [11:0] sel, input logic lk,
                                           input logic st);
      logic [15:0] v;
      v = 16'h0000;
      case (ra)
         `PSL_REG_CONTROL: begin
            v[14:0] = ctl;
         end
         `PSL_REG_STATUS: begin
            v[`PSL_STAT_LINK_BIT] = lk;
         end
         `PSL_REG_EXT_STATUS: begin
            v[`PSL_EXT_LINK_BIT] = lk;
         end
         `PSL_REG_INDICATOR: begin
            v[15:`PSL_IND_SEL_LSB] = sel;
            v[`PSL_IND_STRETCH_BIT] = st;
         end
         default: begin
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction : regRead

   // ***************************************************************
   // Management frame slave
   // ***************************************************************
   psl_pkg::psl_state_t stateReg;
   logic [5:0] onesCnt;
   logic [4:0] bitCnt;
   logic [11:0] hdrShift;
   logic [15:0] dataShift;
   logic readHit;
   logic writeHit;
   logic [4:0] hitReg;
   logic [IW-1:0] hitPort;
   logic [11:0] hdrNext;
   logic [4:0] portOff;
   logic addrHit;
   logic wrStrobe;
   logic [15:0] wrData;

   assign hdrNext = {hdrShift[10:0], mdioSync[1]};
   assign portOff = hdrNext[9:5] - PHY_BASE;
   assign addrHit = ({27'h0, portOff} < PORTS);
   assign wrData = {dataShift[14:0], mdioSync[1]};
   assign wrStrobe = mdcRise && stateReg == psl_pkg::PSL_DATA &&
                     bitCnt == `PSL_DATA_LAST && writeHit;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stateReg <= psl_pkg::PSL_PRE;
         onesCnt <= 6'h00;
         bitCnt <= 5'h00;
         hdrShift <= 12'h000;
         dataShift <= 16'h0000;
         readHit <= 1'b0;
         writeHit <= 1'b0;
         hitReg <= 5'h00;
         hitPort <= '0;
         mdioOut <= 1'b1;
         mdioOeN <= 1'b1;
      end else if (mdcRise) begin
         case (stateReg)
            psl_pkg::PSL_PRE: begin
               if (mdioSync[1]) begin
                  onesCnt <= (onesCnt == `PSL_PREAMBLE_BITS) ? onesCnt : onesCnt + 6'h01;
               end else begin
                  onesCnt <= 6'h00;
                  if (onesCnt == `PSL_PREAMBLE_BITS) begin
                     stateReg <= psl_pkg::PSL_START;
                  end
               end
            end
            psl_pkg::PSL_START: begin
               bitCnt <= 5'h00;
               readHit <= 1'b0;
               writeHit <= 1'b0;
               stateReg <= mdioSync[1] ? psl_pkg::PSL_HDR : psl_pkg::PSL_PRE;
            end
            psl_pkg::PSL_HDR: begin
               bitCnt <= bitCnt + 5'h01;
               if (bitCnt <= `PSL_HDR_LAST) begin
                  hdrShift <= hdrNext;
               end
               if (bitCnt == `PSL_HDR_LAST) begin
                  readHit <= addrHit && hdrNext[11:10] == 2'h2;
                  writeHit <= addrHit && hdrNext[11:10] == 2'h1;
                  hitReg <= hdrNext[4:0];
                  hitPort <= portOff[IW-1:0];
                  dataShift <= regRead(hdrNext[4:0], ctrlReg[portOff[IW-1:0]],
                                       selReg[portOff[IW-1:0]],
                                       linkUp[portOff[IW-1:0]], stretchEnReg);
               end
               if (bitCnt == `PSL_TA_FIRST && readHit) begin
                  mdioOut <= 1'b0;
                  mdioOeN <= 1'b0;
               end
               if (bitCnt == `PSL_TA_LAST) begin
                  mdioOut <= readHit ? dataShift[15] : 1'b1;
                  bitCnt <= 5'h00;
                  stateReg <= psl_pkg::PSL_DATA;
               end
            end
            psl_pkg::PSL_DATA: begin
               bitCnt <= bitCnt + 5'h01;
               dataShift <= wrData;
               mdioOut <= readHit ? dataShift[14] : 1'b1;
               if (bitCnt == `PSL_DATA_LAST) begin
                  mdioOut <= 1'b1;
                  mdioOeN <= 1'b1;
                  onesCnt <= 6'h00;
                  stateReg <= psl_pkg::PSL_PRE;
               end
            end
            default: begin
               stateReg <= psl_pkg::PSL_PRE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Register writes and port reset
   // ***************************************************************
   logic [PORTS-1:0] portResetReq;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stretchEnReg <= `PSL_IND_STRETCH_RESET_VAL;
      end else if (wrStrobe && hitReg == `PSL_REG_INDICATOR) begin
         // A single bit shared by all ports, whichever port address wrote it
         stretchEnReg <= wrData[`PSL_IND_STRETCH_BIT];
      end
   end

   // ***************************************************************
   // Traffic stretching and blink phase
   // ***************************************************************
   logic [MW-1:0] msCnt;
   logic msTick;
   logic [BW-1:0] blinkCnt;
   logic blinkPhase;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         msCnt <= '0;
         msTick <= 1'b0;
         blinkCnt <= '0;
         blinkPhase <= 1'b0;
      end else begin
         msTick <= (msCnt == MW'(MS_CYCLES - 1));
         msCnt <= (msCnt == MW'(MS_CYCLES - 1)) ? '0 : msCnt + MW'(1);
         if (msTick) begin
            blinkCnt <= (blinkCnt == BW'(BLINK_MS - 1)) ? '0 : blinkCnt + BW'(1);
            if (blinkCnt == BW'(BLINK_MS - 1)) begin
               blinkPhase <= ~blinkPhase;
            end
         end
      end
   end

   function automatic logic ledDecode(input logic [3:0] sel, input logic tx, input logic rx,
                                      input logic lk, input logic blink);
      logic on;
      on = 1'b0;
      case (sel)
         psl_pkg::PSL_LED_RX: on = rx;
         psl_pkg::PSL_LED_TX: on = tx;
         psl_pkg::PSL_LED_ACT: on = tx | rx;
         psl_pkg::PSL_LED_LINK: on = lk;
         // Activity blinks the lit link indicator and never lights it alone
         psl_pkg::PSL_LED_LINK_ACT: on = lk & ~((tx | rx) & blink);
         psl_pkg::PSL_LED_OFF: on = 1'b0;
         psl_pkg::PSL_LED_ON: on = 1'b1;
         default: on = 1'b0;
      endcase
      return on;
   endfunction : ledDecode

   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         logic [SW-1:0] txHold;
         logic [SW-1:0] rxHold;
         logic txInd;
         logic rxInd;

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               ctrlReg[p] <= `PSL_CTRL_RESET_VAL;
               selReg[p] <= `PSL_IND_SEL_RESET_VAL;
               portResetReq[p] <= 1'b0;
            end else begin
               portResetReq[p] <= 1'b0;
               if (wrStrobe && hitPort == IW'(p)) begin
                  if (hitReg == `PSL_REG_CONTROL && wrData[`PSL_CTRL_RESET_BIT]) begin
                     // Self-clearing: the port returns to defaults and restarts
                     ctrlReg[p] <= `PSL_CTRL_RESET_VAL;
                     selReg[p] <= `PSL_IND_SEL_RESET_VAL;
                     portResetReq[p] <= 1'b1;
                  end else if (hitReg == `PSL_REG_CONTROL) begin
                     ctrlReg[p] <= wrData[14:0];
                  end else if (hitReg == `PSL_REG_INDICATOR) begin
                     selReg[p] <= wrData[15:`PSL_IND_SEL_LSB];
                  end
               end
            end
         end

         // Retriggered on every event, so back-to-back traffic never gaps
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               txHold <= '0;
               rxHold <= '0;
            end else begin
               if (txActive[p]) begin
                  txHold <= SW'(STRETCH_MS);
               end else if (msTick && txHold != '0) begin
                  txHold <= txHold - SW'(1);
               end
               if (rxActive[p]) begin
                  rxHold <= SW'(STRETCH_MS);
               end else if (msTick && rxHold != '0) begin
                  rxHold <= rxHold - SW'(1);
               end
            end
         end

         assign txInd = txActive[p] | (stretchEnReg & (txHold != '0));
         assign rxInd = rxActive[p] | (stretchEnReg & (rxHold != '0));

         // Outputs registered so the pins never glitch on select changes
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               ledOn[3*p +: 3] <= 3'h0;
               portResetPulse[p] <= 1'b0;
            end else begin
               ledOn[3*p+2] <= ledDecode(selReg[p][11:8], txInd, rxInd, linkUp[p], blinkPhase);
               ledOn[3*p+1] <= ledDecode(selReg[p][7:4], txInd, rxInd, linkUp[p], blinkPhase);
               ledOn[3*p] <= ledDecode(selReg[p][3:0], txInd, rxInd, linkUp[p], blinkPhase);
               portResetPulse[p] <= portResetReq[p];
            end
         end
      end
   endgenerate

endmodule : psl_port_status_led

`default_nettype wire

/* shared/psl_consts.svh */
// Constants of the port status indicator block: register offsets, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from the design file.
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define PSL_REG_CONTROL 5'h00
`define PSL_REG_STATUS 5'h01
`define PSL_REG_EXT_STATUS 5'h11
`define PSL_REG_INDICATOR 5'h14

// ***************************************************************
// Field positions
// ***************************************************************
`define PSL_CTRL_RESET_BIT 15
`define PSL_STAT_LINK_BIT 2
`define PSL_EXT_LINK_BIT 10
`define PSL_IND_STRETCH_BIT 1
`define PSL_IND_SEL_LSB 4

// ***************************************************************
// Reset values
// ***************************************************************
`define PSL_CTRL_RESET_VAL 15'h0000
`define PSL_IND_SEL_RESET_VAL 12'hd10
`define PSL_IND_STRETCH_RESET_VAL 1'b1
`define PSL_PHY_BASE 5'h00

// ***************************************************************
// Frame and timing figures
// ***************************************************************
`define PSL_PREAMBLE_BITS 6'd32
`define PSL_HDR_LAST 5'd11
`define PSL_TA_FIRST 5'd12
`define PSL_TA_LAST 5'd13
`define PSL_DATA_LAST 5'd15
`define PSL_CLK_PERIOD_NS 5
`define PSL_MS_NS 1000000
`define PSL_STRETCH_MS 30
`define PSL_BLINK_MS 50

`endif

/* shared/psl_pkg.sv */
// Types of the port status indicator block.
// Assumes nothing of its surroundings.
`default_nettype none

package psl_pkg;

   // Serial management frame states, Gray along the frame
   typedef enum logic [1:0] {
      PSL_PRE = 2'h0,
      PSL_START = 2'h1,
      PSL_HDR = 2'h3,
      PSL_DATA = 2'h2
   } psl_state_t;

   // Indicator function codes
   typedef enum logic [3:0] {
      PSL_LED_RX = 4'h0,
      PSL_LED_TX = 4'h1,
      PSL_LED_ACT = 4'h2,
      PSL_LED_LINK = 4'h3,
      PSL_LED_LINK_ACT = 4'hd,
      PSL_LED_OFF = 4'he,
      PSL_LED_ON = 4'hf
   } psl_led_t;

endpackage : psl_pkg

`default_nettype wire
